// ==== shared/pmar_map.svh ====
`ifndef PMAR_MAP_SVH
`define PMAR_MAP_SVH

// byte offsets of the management register window
`define PMAR_OFS_CTRL_LO    12'h0510
`define PMAR_OFS_CTRL_HI    12'h0511
`define PMAR_OFS_PHY_SEL    12'h0512
`define PMAR_OFS_PHY_REG    12'h0513
`define PMAR_OFS_DATA_LO    12'h0514
`define PMAR_OFS_DATA_HI    12'h0515
`define PMAR_OFS_NET_ACC    12'h0516
`define PMAR_OFS_HOST_ACC   12'h0517

// bit positions within the 16-bit control/status word
`define PMAR_BIT_BUSY       15
`define PMAR_BIT_CMD_ERR    14
`define PMAR_BIT_RD_ERR     13
`define PMAR_BIT_CMD_HI     9
`define PMAR_BIT_CMD_LO     8
`define PMAR_BIT_LINK       2
`define PMAR_BIT_IF_CTRL    1
`define PMAR_BIT_WEN        0
// bit positions within the access-state bytes
`define PMAR_BIT_ACC        0
`define PMAR_BIT_FORCE      1

// reset values
`define PMAR_RST_BYTE       8'h00
`define PMAR_RST_FIELD5     5'h00
`define PMAR_RST_DATA       16'h0000
`define PMAR_RST_IF_CTRL    1'b1

`endif

// ==== shared/pmar_pkg.sv ====
package pmar_pkg;

    typedef enum logic [1:0] {
        PMAR_CMD_NONE  = 2'h0,
        PMAR_CMD_READ  = 2'h1,
        PMAR_CMD_WRITE = 2'h2,
        PMAR_CMD_RSVD  = 2'h3
    } pmar_cmd_e;

    // one byte-wide register access from either side
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } pmar_req_s;

    // request towards the serial management engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  phy_addr;
        logic [4:0]  reg_addr;
        logic [15:0] wdata;
    } pmar_phy_req_s;

endpackage

// ==== verilog/pmar_top.sv ====
// Overview of operation
// R1: busy bit 15 high while command runs
// R2: invalid or unenabled write sets error bit 14
// R3: valid command or 00 clears command error
// R4: failed read sets bit 13; register write clears; only writes to the control word bytes clear it here
// R5: command 00 idle, 01 read, 10 write
// R6: command write starts; read shows running command
// R7: command field self-clears when busy falls
// R8: writing 00 clears both error bits
// R9: link detect reads 0 until configuration succeeds
// R10: link enable latched only at first load
// R11: interface control bit reads constant 1
// R12: write enable reads 1 under host ownership
// R13: write enable clears at frame start/access end; a same-cycle write still lands
// R14: only current owner may write registers; the host access byte takes writes from either side, the network access byte from the network only
// R15: writes ignored while busy; access-state byte writes still land
// R16: five-bit register number used as target
// R17: multi-byte registers little-endian
// R18: host access bit selects owner
// R19: network claim blocks host taking access
// R20: phy_select_address is field plus offset
// R21: write sends data; read loads data
`include "pmar_map.svh"

module pmar_top
    import pmar_pkg::*;
#(
    parameter int PHY_ADDR_OFFSET = 0
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire pmar_req_s     net_req,
    output logic [7:0]         net_rdata,
    input  wire pmar_req_s     host_req,
    output logic [7:0]         host_rdata,
    input  wire logic          sof_pulse,
    input  wire logic          host_access_end,
    input  wire logic          cfg_load_done,
    input  wire logic          cfg_load_ok,
    input  wire logic          cfg_link_detect_en,
    output pmar_phy_req_s      phy_req,
    input  wire logic          phy_done,
    input  wire logic          phy_read_fail,
    input  wire logic [15:0]   phy_rdata,
    output logic               link_detect_active
);

    if (PHY_ADDR_OFFSET < 0 || PHY_ADDR_OFFSET > 31) begin : g_chk
        $error("PHY_ADDR_OFFSET must fit in five bits");
    end

    localparam logic [4:0] OFS5 = 5'(PHY_ADDR_OFFSET);

    typedef enum {PMAR_ST_IDLE, PMAR_ST_WAIT} pmar_state_e;

    pmar_state_e    state,      next_state;
    pmar_cmd_e      cmd,        next_cmd;
    logic           cmd_err,    next_cmd_err;
    logic           rd_err,     next_rd_err;
    logic           wen,        next_wen;
    logic [4:0]     phy_sel,    next_phy_sel;
    logic [4:0]     phy_reg,    next_phy_reg;
    logic [15:0]    data,       next_data;
    logic           net_acc,    next_net_acc;
    logic           host_acc,   next_host_acc;
    logic           force_acc,  next_force_acc;
    logic           cfg_seen,   next_cfg_seen;
    logic           link,       next_link;
    logic [7:0]     next_net_rdata;
    logic [7:0]     next_host_rdata;
    pmar_phy_req_s  next_phy_req;

    logic           busy;
    logic           wen_eff;
    pmar_req_s      own;
    logic           own_wr;
    pmar_cmd_e      wr_cmd;

    always_comb begin
        busy    = (state != PMAR_ST_IDLE);                              // R1
        wen_eff = host_acc | wen;                                       // R12
        own     = host_acc ? host_req : net_req;                        // R18
        own_wr  = own.wr && !busy;                                      // R14 R15
        wr_cmd  = pmar_cmd_e'(own.wdata[1:0]);
    end

    // byte view of the window, low byte at the low address
    function automatic logic [7:0] rd_byte(input logic [11:0] a);
        logic [7:0] r;
        r = `PMAR_RST_BYTE;
        case (a)                                                        // R17
            `PMAR_OFS_CTRL_LO:  r = {OFS5, link, `PMAR_RST_IF_CTRL, wen_eff}; // R9 R11 R12
            `PMAR_OFS_CTRL_HI:  r = {busy, cmd_err, rd_err, 3'h0, cmd};  // R1 R6
            `PMAR_OFS_PHY_SEL:  r = {3'h0, phy_sel};
            `PMAR_OFS_PHY_REG:  r = {3'h0, phy_reg};
            `PMAR_OFS_DATA_LO:  r = data[7:0];
            `PMAR_OFS_DATA_HI:  r = data[15:8];
            `PMAR_OFS_NET_ACC:  r = {7'h00, net_acc};
            `PMAR_OFS_HOST_ACC: r = {6'h00, force_acc, host_acc};
            default:            r = `PMAR_RST_BYTE;
        endcase
        return r;
    endfunction

    always_comb begin
        next_state      = state;
        next_cmd        = cmd;
        next_cmd_err    = cmd_err;
        next_rd_err     = rd_err;
        next_wen        = wen;
        next_phy_sel    = phy_sel;
        next_phy_reg    = phy_reg;
        next_data       = data;
        next_net_acc    = net_acc;
        next_host_acc   = host_acc;
        next_force_acc  = force_acc;
        next_cfg_seen   = cfg_seen;
        next_link       = link;
        next_phy_req    = phy_req;
        next_phy_req.valid = 1'b0;
        next_net_rdata  = net_req.rd ? rd_byte(net_req.addr) : net_rdata;
        next_host_rdata = host_req.rd ? rd_byte(host_req.addr) : host_rdata;

        // a write in the same cycle as frame start still lands
        if (sof_pulse || host_access_end) begin
            next_wen = 1'b0;                                            // R13
        end

        // ownership handshake; busy does not gate these
        if (net_req.wr && net_req.addr == `PMAR_OFS_NET_ACC && !host_acc) begin
            next_net_acc = net_req.wdata[`PMAR_BIT_ACC];                // R19
        end
        if (net_req.wr && net_req.addr == `PMAR_OFS_HOST_ACC) begin
            next_force_acc = net_req.wdata[`PMAR_BIT_FORCE];
        end
        if (host_req.wr && host_req.addr == `PMAR_OFS_HOST_ACC
                && !force_acc && !net_acc) begin
            next_host_acc = host_req.wdata[`PMAR_BIT_ACC];              // R19
        end
        if (force_acc) begin
            next_host_acc = 1'b0;
        end

        if (own_wr) begin
            case (own.addr)
                `PMAR_OFS_CTRL_LO: begin
                    next_rd_err = 1'b0;                                 // R4
                    if (!host_acc) begin
                        next_wen = own.wdata[`PMAR_BIT_WEN];
                    end
                end
                `PMAR_OFS_CTRL_HI: begin
                    next_rd_err = 1'b0;                                 // R4
                    case (wr_cmd)                                       // R5
                        PMAR_CMD_NONE: begin
                            next_cmd_err = 1'b0;                        // R3 R8
                        end
                        PMAR_CMD_READ, PMAR_CMD_WRITE: begin
                            if (wr_cmd == PMAR_CMD_WRITE && !wen_eff) begin
                                next_cmd_err = 1'b1;                    // R2
                            end else begin
                                next_cmd_err = 1'b0;                    // R3
                                next_cmd     = wr_cmd;                  // R6
                                next_state   = PMAR_ST_WAIT;
                                next_phy_req.valid    = 1'b1;
                                next_phy_req.write    = (wr_cmd == PMAR_CMD_WRITE); // R21
                                next_phy_req.phy_addr = 5'(phy_sel + OFS5); // R20
                                next_phy_req.reg_addr = phy_reg;        // R16
                                next_phy_req.wdata    = data;           // R21
                            end
                        end
                        default: begin
                            next_cmd_err = 1'b1;                        // R2
                        end
                    endcase
                end
                `PMAR_OFS_PHY_SEL: next_phy_sel = own.wdata[4:0];
                `PMAR_OFS_PHY_REG: next_phy_reg = own.wdata[4:0];       // R16
                `PMAR_OFS_DATA_LO: next_data[7:0] = own.wdata;          // R17
                `PMAR_OFS_DATA_HI: next_data[15:8] = own.wdata;         // R17
                default: ;
            endcase
        end

        case (state)
            PMAR_ST_IDLE: ;
            PMAR_ST_WAIT: begin
                if (phy_done) begin
                    if (cmd == PMAR_CMD_READ) begin
                        if (phy_read_fail) begin
                            next_rd_err = 1'b1;                         // R4
                        end else begin
                            next_data = phy_rdata;                      // R21
                        end
                    end
                    next_cmd   = PMAR_CMD_NONE;                         // R7
                    next_state = PMAR_ST_IDLE;                          // R1
                end
            end
            default: next_state = PMAR_ST_IDLE;
        endcase

        // only the first load after reset counts, good or bad
        if (cfg_load_done && !cfg_seen) begin
            next_cfg_seen = 1'b1;                                       // R10
            next_link     = cfg_load_ok & cfg_link_detect_en;           // R9
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state              <= PMAR_ST_IDLE;
            cmd                <= PMAR_CMD_NONE;
            cmd_err            <= 1'b0;
            rd_err             <= 1'b0;
            wen                <= 1'b0;
            phy_sel            <= `PMAR_RST_FIELD5;
            phy_reg            <= `PMAR_RST_FIELD5;
            data               <= `PMAR_RST_DATA;
            net_acc            <= 1'b0;
            host_acc           <= 1'b0;
            force_acc          <= 1'b0;
            cfg_seen           <= 1'b0;
            link               <= 1'b0;
            net_rdata          <= `PMAR_RST_BYTE;
            host_rdata         <= `PMAR_RST_BYTE;
            phy_req            <= '0;
            link_detect_active <= 1'b0;
        end else begin
            state              <= next_state;
            cmd                <= next_cmd;
            cmd_err            <= next_cmd_err;
            rd_err             <= next_rd_err;
            wen                <= next_wen;
            phy_sel            <= next_phy_sel;
            phy_reg            <= next_phy_reg;
            data               <= next_data;
            net_acc            <= next_net_acc;
            host_acc           <= next_host_acc;
            force_acc          <= next_force_acc;
            cfg_seen           <= next_cfg_seen;
            link               <= next_link;
            net_rdata          <= next_net_rdata;
            host_rdata         <= next_host_rdata;
            phy_req            <= next_phy_req;
            link_detect_active <= next_link;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_cmd_wr;
        own_wr && own.addr == `PMAR_OFS_CTRL_HI;
    endsequence

    sequence s_start(pmar_cmd_e c);
        s_cmd_wr and (wr_cmd == c) and (c == PMAR_CMD_READ || wen_eff);
    endsequence

    AST_START_BUSY: assert property (s_start(PMAR_CMD_READ) |=> busy && phy_req.valid // R1
        && cmd == PMAR_CMD_READ && !phy_req.write)
        else $error("read command did not raise busy");

    AST_WR_NO_WEN: assert property (s_cmd_wr and (wr_cmd == PMAR_CMD_WRITE) // R2
        and !wen_eff |=> cmd_err && !busy)
        else $error("write without enable not flagged");

    AST_RSVD_CMD: assert property (s_cmd_wr and (wr_cmd == PMAR_CMD_RSVD) // R5
        |=> cmd_err && cmd == PMAR_CMD_NONE)
        else $error("reserved command not flagged");

    AST_CLR00: assert property (s_cmd_wr and (wr_cmd == PMAR_CMD_NONE) // R8
        |=> !cmd_err && !rd_err)
        else $error("command 00 did not clear errors");

    AST_BUSY_FALL: assert property ($fell(busy) |-> cmd == PMAR_CMD_NONE) // R7
        else $error("command field still set after busy fell");

    AST_BUSY_BLOCK: assert property (busy && own.wr && own.addr == `PMAR_OFS_PHY_SEL // R15
        |=> $stable(phy_sel))
        else $error("write accepted while busy");

    AST_NOT_OWNER: assert property (!host_acc && host_req.wr && !net_req.wr // R14
        |=> $stable(phy_sel) && $stable(phy_reg) && ($stable(data) || $past(busy)))
        else $error("non-owner write changed data");

    AST_LINK_ZERO: assert property (!cfg_seen |-> !link && !link_detect_active) // R9
        else $error("link detect active before configuration");

    AST_LINK_HOLD: assert property (cfg_seen |=> $stable(link)) // R10
        else $error("link enable changed after first load");

    AST_WEN_SOF: assert property (sof_pulse && !own_wr |=> !wen) // R13
        else $error("write enable survived frame start");

    AST_READ_LOAD: assert property (state == PMAR_ST_WAIT && cmd == PMAR_CMD_READ // R21
        && phy_done && !phy_read_fail |=> data == $past(phy_rdata) && !busy)
        else $error("read data not loaded");

    AST_RD_FAIL: assert property (state == PMAR_ST_WAIT && cmd == PMAR_CMD_READ // R4
        && phy_done && phy_read_fail |=> rd_err ##1 rd_err || $past(own_wr))
        else $error("read failure not flagged");

    AST_PHY_ADDR: assert property (s_start(PMAR_CMD_READ) // R20
        |=> phy_req.phy_addr == 5'($past(phy_sel) + OFS5))
        else $error("phy_select_address not offset");

endmodule // pmar_top

// ==== sim/pmar_phy_model.sv ====
module pmar_phy_model
    import pmar_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire pmar_phy_req_s phy_req,
    input  wire logic [3:0]    lat,
    input  wire logic          fail,
    output logic               phy_done,
    output logic               phy_read_fail,
    output logic [15:0]        phy_rdata,
    output pmar_phy_req_s      last_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic       run;
    // answer lines toggle outside the done cycle so stale data never matches
    always_ff @(posedge mclk) begin
        phy_done      <= 1'b0;
        phy_read_fail <= ~phy_read_fail;
        phy_rdata     <= ~phy_rdata;
        if (sys_rst) begin
            run           <= 1'b0;
            cnt           <= 4'h0;
            phy_read_fail <= 1'b0;
            phy_rdata     <= 16'h0000;
            last_req      <= '0;
        end else if (phy_req.valid) begin
            last_req <= phy_req;
            run      <= 1'b1;
            cnt      <= lat;
        end else if (run && cnt == 4'h0) begin
            run           <= 1'b0;
            phy_done      <= 1'b1;
            phy_read_fail <= fail & ~last_req.write;
            phy_rdata     <= {1'b1, last_req.phy_addr, last_req.reg_addr, 5'h15};
        end else if (run) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // pmar_phy_model

// ==== sim/pmar_top_tb.sv ====
module pmar_top_tb import pmar_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] OFS = 5'h05;
    logic          mclk, sys_rst, sof_pulse, host_access_end, fail;
    logic          cfg_load_done, cfg_load_ok, cfg_link_detect_en;
    logic          phy_done, phy_read_fail, link_detect_active;
    pmar_req_s     net_req, host_req;
    logic [7:0]    net_rdata, host_rdata;
    logic [15:0]   phy_rdata;
    logic [3:0]    lat;
    pmar_phy_req_s phy_req, last_req;
    int            bad_count, num_checks;

    pmar_top #(.PHY_ADDR_OFFSET(5)) pmar_top_i (.mclk(mclk), .sys_rst(sys_rst),
        .net_req(net_req), .net_rdata(net_rdata), .host_req(host_req),
        .host_rdata(host_rdata), .sof_pulse(sof_pulse), .host_access_end(host_access_end),
        .cfg_load_done(cfg_load_done), .cfg_load_ok(cfg_load_ok),
        .cfg_link_detect_en(cfg_link_detect_en), .phy_req(phy_req), .phy_done(phy_done),
        .phy_read_fail(phy_read_fail), .phy_rdata(phy_rdata),
        .link_detect_active(link_detect_active));
    pmar_phy_model pmar_phy_model_i (.mclk(mclk), .sys_rst(sys_rst), .phy_req(phy_req),
        .lat(lat), .fail(fail), .phy_done(phy_done), .phy_read_fail(phy_read_fail),
        .phy_rdata(phy_rdata), .last_req(last_req));

    task automatic tally_and_finish();
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input bit h, input bit w, input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk);
        if (h)
            host_req = '{w, !w, a, d};
        else
            net_req = '{w, !w, a, d};
        @(negedge mclk);
        host_req = '0;
        net_req = '0;
    endtask
    task automatic rd(input bit h, input logic [11:0] a, input logic [7:0] e, input string n);
        bus(h, 0, a, 8'h00);
        chk(n, {8'h00, e}, {8'h00, h ? host_rdata : net_rdata});
    endtask
    task automatic start(input bit h, input logic [7:0] s, input logic [7:0] r,
                         input logic [7:0] c);
        bus(h, 1, 12'h512, s);
        bus(h, 1, 12'h513, r);
        bus(h, 1, 12'h511, c);
    endtask
    task automatic wait_idle(input bit h);
        int i;
        for (i = 0; i < 40; i++) begin
            bus(h, 0, 12'h511, 8'h00);
            if ((h ? host_rdata[7] : net_rdata[7]) === 1'b0)
                break;
        end
        chk("idle wait", 16'h0000, {15'h0000, i == 40});
    endtask
    task automatic pulse(input int k);
        @(negedge mclk);
        if (k == 0)
            sof_pulse = 1'b1;
        else
            cfg_load_done = 1'b1;
        @(negedge mclk);
        sof_pulse = 1'b0;
        cfg_load_done = 1'b0;
        @(negedge mclk);
    endtask
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
    endtask

    task automatic t_reset();
        rd(0, 12'h510, {OFS, 3'b010}, "ctrl lo");
        for (int k = 1; k < 8; k++)
            rd(k[0], 12'h510 + 12'(k), 8'h00, "reset byte");
        rd(0, 12'h520, 8'h00, "unmapped");
    endtask
    task automatic t_read();
        lat = 4'h9;
        start(0, 8'h1E, 8'h11, 8'h01);
        chk("req", {1'b1, 1'b0, 5'h03, 5'h11, 4'h0}, phy_req[27:12]);
        rd(0, 12'h511, 8'h81, "busy cmd");
        bus(0, 1, 12'h512, 8'h07);
        rd(0, 12'h512, 8'h1E, "busy write");
        wait_idle(0);
        rd(0, 12'h514, 8'h35, "data lo");
        rd(0, 12'h515, 8'h8E, "data hi");
        rd(0, 12'h511, 8'h00, "cmd clear");
    endtask
    task automatic t_err();
        lat = 4'h1;
        fail = 1'b1;
        start(0, 8'h01, 8'h02, 8'h01);
        wait_idle(0);
        rd(0, 12'h511, 8'h20, "rd err");
        bus(0, 1, 12'h511, 8'h03);
        rd(0, 12'h511, 8'h40, "bad cmd");
        bus(0, 1, 12'h511, 8'h00);
        rd(0, 12'h511, 8'h00, "cmd 00");
        start(0, 8'h01, 8'h02, 8'h01);
        wait_idle(0);
        bus(0, 1, 12'h510, 8'h00);
        rd(0, 12'h511, 8'h00, "rd err wr");
        fail = 1'b0;
        bus(0, 1, 12'h511, 8'h02);
        rd(0, 12'h511, 8'h40, "no wen");
        start(0, 8'h01, 8'h02, 8'h01);
        wait_idle(0);
        rd(0, 12'h511, 8'h00, "valid cmd");
    endtask
    task automatic t_write();
        bus(0, 1, 12'h510, 8'h01);
        bus(0, 1, 12'h514, 8'h34);
        bus(0, 1, 12'h515, 8'h12);
        start(0, 8'h02, 8'h09, 8'h02);
        chk("wr req", 16'h1234, phy_req.wdata);
        chk("wr flag", 16'h0001, {15'h0000, phy_req.write});
        wait_idle(0);
        rd(0, 12'h510, {OFS, 3'b011}, "wen set");
        pulse(0);
        rd(0, 12'h510, {OFS, 3'b010}, "wen sof");
    endtask
    task automatic t_own();
        bus(1, 1, 12'h512, 8'h0A);
        rd(1, 12'h512, 8'h02, "host refused");
        bus(0, 1, 12'h516, 8'h01);
        bus(1, 1, 12'h517, 8'h01);
        rd(1, 12'h517, 8'h00, "net claim");
        bus(0, 1, 12'h516, 8'h00);
        bus(0, 1, 12'h510, 8'h01);
        bus(1, 1, 12'h517, 8'h01);
        rd(0, 12'h517, 8'h01, "host owns");
        rd(1, 12'h510, {OFS, 3'b011}, "host wen");
        bus(1, 1, 12'h512, 8'h0A);
        bus(0, 1, 12'h512, 8'h0B);
        rd(0, 12'h512, 8'h0A, "owner write");
        start(1, 8'h0A, 8'h03, 8'h01);
        wait_idle(1);
        rd(1, 12'h515, 8'hBC, "host read");
        @(negedge mclk);
        host_access_end = 1'b1;
        @(negedge mclk);
        host_access_end = 1'b0;
        bus(1, 1, 12'h517, 8'h00);
        rd(0, 12'h510, {OFS, 3'b010}, "wen end");
    endtask
    task automatic t_link();
        cfg_load_ok = 1'b0;
        pulse(1);
        cfg_load_ok = 1'b1;
        pulse(1);
        chk("late load", 16'h0000, {15'h0000, link_detect_active});
        do_reset();
        pulse(1);
        chk("link on", 16'h0001, {15'h0000, link_detect_active});
        rd(0, 12'h510, {OFS, 3'b110}, "link bit");
        cfg_link_detect_en = 1'b0;
        pulse(1);
        chk("reload", 16'h0001, {15'h0000, link_detect_active});
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        #(8 * 20000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {sof_pulse, host_access_end, fail, cfg_load_done} = 4'h0;
        cfg_load_ok = 1'b0;
        cfg_link_detect_en = 1'b1;
        net_req = '0;
        host_req = '0;
        lat = 4'h1;
        do_reset();
        t_reset();
        t_read();
        t_err();
        t_write();
        t_own();
        t_link();
        tally_and_finish();
    end
endmodule // pmar_top_tb
